// [include/cfg_err_pkg.sv]
package cfg_err_pkg;
  localparam int SYS_PERIOD_NS = 10;
  localparam int SM_BIT_NS = 100;
  // half a bit time on the slave-to-master line, least time rounded up
  localparam int SM_HALF_CYC = (SM_BIT_NS / 2 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int WORD_BITS = 9;
  localparam logic [3:0] CNT_LAST = 4'(WORD_BITS - 1);
  localparam logic [4:0] BIT_STEP_LAST = 5'(2 * WORD_BITS - 1);
  localparam logic [1:0] WIDX_ADDR = 2'h0;
  localparam logic [1:0] WIDX_SUB = 2'h1;
  localparam logic [1:0] WIDX_DATA = 2'h3;
  localparam int CTRL_RW_BIT = 7;
  localparam int CTRL_INT_BIT = 6;
  localparam int ST_WIDTH = 3;
  localparam int ST_HDR_BIT = 0;
  localparam int ST_DATA_BIT = 1;
  localparam int ST_USER_BIT = 2;
  localparam logic [ST_WIDTH-1:0] STATUS_RST = 3'h0;

  typedef enum logic [2:0] {EV_ADDR, EV_SUB, EV_HDR_OK, EV_HDR_ERR, EV_DATA, EV_END_OK,
    EV_END_ERR} ev_kind_t;

  function automatic logic [3:0] nib_xor(input logic [7:0] w);
    return w[3:0] ^ w[7:4];
  endfunction

  function automatic logic [ST_WIDTH-1:0] maj3(input logic [ST_WIDTH-1:0] a,
    input logic [ST_WIDTH-1:0] b, input logic [ST_WIDTH-1:0] c);
    return (a & b) | (a & c) | (b & c);
  endfunction
endpackage

// [verilog/link_rx.sv]
`timescale 1ns/1ns
module link_rx
  import cfg_err_pkg::*;
(
  input wire logic link_clk,
  input wire logic rst_b,
  input wire logic frame_start,
  input wire logic rx_bit,
  output logic ev_tgl,
  output ev_kind_t ev_kind,
  output logic [7:0] ev_word
);
  logic [3:0] cnt_q, cnt_d, cnt, hsum_q, hsum_d, hsum;
  logic [7:0] sh_q, sh_d, dsum_q, dsum_d, dsum, word_q, word_d;
  logic [1:0] widx_q, widx_d, widx;
  logic hold_q, hold_d, hold, tgl_q, tgl_d;
  ev_kind_t kind_q, kind_d;

  // results are taken on the last bit edge: the link clock may stop right after it
  always_comb
  begin
    cnt = frame_start ? 4'h0 : cnt_q;
    widx = frame_start ? WIDX_ADDR : widx_q;
    hsum = frame_start ? 4'h0 : hsum_q;
    dsum = frame_start ? 8'h00 : dsum_q;
    hold = frame_start ? 1'b0 : hold_q;
    cnt_d = cnt;
    sh_d = sh_q;
    widx_d = widx;
    hsum_d = hsum;
    dsum_d = dsum;
    hold_d = hold;
    tgl_d = tgl_q;
    kind_d = kind_q;
    word_d = word_q;
    if (!hold)
    begin
      if (cnt == CNT_LAST)
      begin
        cnt_d = 4'h0;
        tgl_d = ~tgl_q;
        word_d = sh_q;
        if (widx != WIDX_DATA)
        begin
          hsum_d = hsum ^ nib_xor(sh_q);
          widx_d = widx + 2'h1;
          if (rx_bit)
          begin
            kind_d = EV_HDR_ERR;
            hold_d = 1'b1;
          end
          else if (widx == WIDX_ADDR)
            kind_d = EV_ADDR;
          else if (widx == WIDX_SUB)
            kind_d = EV_SUB;
          else if (hsum_d != 4'h0)
          begin
            kind_d = EV_HDR_ERR;
            hold_d = 1'b1;
          end
          else
            kind_d = EV_HDR_OK;
        end
        else if (rx_bit)
        begin
          kind_d = (sh_q == dsum) ? EV_END_OK : EV_END_ERR;
          hold_d = 1'b1;
        end
        else
        begin
          dsum_d = dsum ^ sh_q;
          kind_d = EV_DATA;
        end
      end
      else
      begin
        sh_d = {rx_bit, sh_q[7:1]};
        cnt_d = cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge link_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      widx_q <= WIDX_ADDR;
      hsum_q <= 4'h0;
      dsum_q <= 8'h00;
      hold_q <= 1'b1;
      tgl_q <= 1'b0;
      kind_q <= EV_ADDR;
      word_q <= 8'h00;
    end
    else
    begin
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      widx_q <= widx_d;
      hsum_q <= hsum_d;
      dsum_q <= dsum_d;
      hold_q <= hold_d;
      tgl_q <= tgl_d;
      kind_q <= kind_d;
      word_q <= word_d;
    end
  end

  assign ev_tgl = tgl_q;
  assign ev_kind = kind_q;
  assign ev_word = word_q;

  chk_last_flag_hdr: assert property (@(posedge link_clk) disable iff (!rst_b)
    (!hold && cnt == CNT_LAST && widx != WIDX_DATA && rx_bit) |=> (kind_q == EV_HDR_ERR && hold_q))
    else $error("header word with last flag was not rejected");
endmodule // link_rx

// [verilog/irq_tx.sv]
`timescale 1ns/1ns
module irq_tx
  import cfg_err_pkg::*;
#(
  parameter int HALF_CYC = SM_HALF_CYC
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [7:0] addr,
  output logic busy,
  output logic sm_clk,
  output logic sm_data,
  output logic sm_oe
);
  typedef enum {TS_IDLE, TS_START, TS_BITS, TS_STOP} tx_st_t;
  localparam logic [7:0] DIV_LAST = 8'(HALF_CYC - 1);

  tx_st_t st_q, st_d;
  logic [7:0] div_q, div_d;
  logic [4:0] step_q, step_d;
  logic [8:0] sr_q, sr_d;
  logic clk_q, clk_d, dat_q, dat_d, oe_q, oe_d, half_end;

  always_comb
  begin
    half_end = (div_q == DIV_LAST);
    st_d = st_q;
    div_d = half_end ? 8'h00 : div_q + 8'h01;
    step_d = step_q;
    sr_d = sr_q;
    clk_d = clk_q;
    dat_d = dat_q;
    oe_d = oe_q;
    case (st_q)
      TS_IDLE:
      begin
        div_d = 8'h00;
        if (start)
        begin
          // single word frame: own address with the last-word flag set
          st_d = TS_START;
          sr_d = {1'b1, addr};
          oe_d = 1'b1;
          dat_d = 1'b0;
          clk_d = 1'b1;
        end
      end
      TS_START:
        if (half_end)
        begin
          st_d = TS_BITS;
          step_d = 5'h00;
          clk_d = 1'b0;
          dat_d = sr_q[0];
        end
      TS_BITS:
        if (half_end)
        begin
          step_d = step_q + 5'h01;
          if (!step_q[0])
            clk_d = 1'b1;
          else if (step_q == BIT_STEP_LAST)
          begin
            st_d = TS_STOP;
            step_d = 5'h00;
            clk_d = 1'b0;
            dat_d = 1'b0;
          end
          else
          begin
            clk_d = 1'b0;
            sr_d = sr_q >> 1;
            dat_d = sr_q[1];
          end
        end
      default:
        if (half_end)
        begin
          step_d = step_q + 5'h01;
          if (step_q == 5'h00)
            clk_d = 1'b1;
          else if (step_q == 5'h01)
            dat_d = 1'b1;
          else
          begin
            st_d = TS_IDLE;
            oe_d = 1'b0;
          end
        end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= TS_IDLE;
      div_q <= 8'h00;
      step_q <= 5'h00;
      sr_q <= 9'h000;
      clk_q <= 1'b1;
      dat_q <= 1'b1;
      oe_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      div_q <= div_d;
      step_q <= step_d;
      sr_q <= sr_d;
      clk_q <= clk_d;
      dat_q <= dat_d;
      oe_q <= oe_d;
    end
  end

  assign busy = (st_q != TS_IDLE);
  assign sm_clk = clk_q;
  assign sm_data = dat_q;
  assign sm_oe = oe_q;

  chk_start_cond_shape: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(oe_q) |-> (clk_q && !dat_q) ##5 (!clk_q && dat_q == $past(sr_q[0])) ##5 clk_q)
    else $error("interrupt frame does not open with start condition and first bit");
endmodule // irq_tx

// [verilog/cfg_slave_err.sv]
`timescale 1ns/1ns
// Behaviour
// - four-bit check follows every header
// - bad header drops the whole frame
// - bad header sends error interrupt at once
// - one trailer byte checks the data block
// - bad data check still delivers the data
// - bad data check sends error interrupt
// - status records kind of interrupt raised
// - host board may raise a user interrupt
// - detect only, never correct errors
// - status kept in triplicated voted storage
// - header check is xor of all nibbles
// - trailer is xor of data low bytes
// - nine-bit words, lsb first, gap between
// - bit eight set only on last word
module cfg_slave_err
  import cfg_err_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic frame_start,
  input wire logic rx_bit,
  input wire logic [7:0] slave_addr,
  input wire logic user_irq_req,
  input wire logic status_read,
  output logic data_valid,
  output logic [7:0] data_byte,
  output logic [7:0] data_sub,
  output logic data_rd,
  output logic data_int,
  output logic frame_done,
  output logic frame_data_bad,
  output logic [ST_WIDTH-1:0] irq_status,
  output logic irq_pending,
  output logic sm_clk,
  output logic sm_data,
  output logic sm_oe
);
  typedef enum {FR_IDLE, FR_HDR, FR_DATA} fr_t;

  logic tgl_raw;
  ev_kind_t kind_raw;
  logic [7:0] word_raw;

  link_rx u_link_rx (
    .link_clk(link_clk),
    .rst_b(rst_b),
    .frame_start(frame_start),
    .rx_bit(rx_bit),
    .ev_tgl(tgl_raw),
    .ev_kind(kind_raw),
    .ev_word(word_raw)
  );

  // event crossing: kind and word are held in the link domain until the next
  // word, at least nine link clocks later, so they are stable once seen here
  logic tg1_q, tg2_q, tg3_q, seen_q, seen_d, ev_hit;
  logic u1_q, u2_q, u3_q, ulvl_q, ulvl_d, u_rise;

  always_comb
  begin
    ev_hit = (tg2_q == tg3_q) && (tg3_q != seen_q);
    seen_d = (tg2_q == tg3_q) ? tg3_q : seen_q;
    ulvl_d = (u2_q == u3_q) ? u3_q : ulvl_q;
    u_rise = ulvl_d && !ulvl_q;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tg1_q <= 1'b0;
      tg2_q <= 1'b0;
      tg3_q <= 1'b0;
      seen_q <= 1'b0;
      u1_q <= 1'b0;
      u2_q <= 1'b0;
      u3_q <= 1'b0;
      ulvl_q <= 1'b0;
    end
    else
    begin
      tg1_q <= tgl_raw;
      tg2_q <= tg1_q;
      tg3_q <= tg2_q;
      seen_q <= seen_d;
      u1_q <= user_irq_req;
      u2_q <= u1_q;
      u3_q <= u2_q;
      ulvl_q <= ulvl_d;
    end
  end

  fr_t fr_q, fr_d;
  logic hit_q, hit_d, rw_q, rw_d, int_q, int_d, dv_q, dv_d, done_q, done_d, bad_q, bad_d;
  logic [7:0] sub_q, sub_d, db_q, db_d, psub_q, psub_d;
  logic hdr_err, dat_err;

  always_comb
  begin
    fr_d = fr_q;
    hit_d = hit_q;
    rw_d = rw_q;
    int_d = int_q;
    sub_d = sub_q;
    psub_d = psub_q;
    db_d = db_q;
    dv_d = 1'b0;
    done_d = 1'b0;
    bad_d = bad_q;
    hdr_err = 1'b0;
    dat_err = 1'b0;
    if (ev_hit)
    begin
      case (kind_raw)
        EV_ADDR:
        begin
          hit_d = (word_raw == slave_addr);
          fr_d = FR_HDR;
        end
        EV_SUB:
          psub_d = word_raw;
        EV_HDR_OK:
        begin
          // header fields reach the outputs only once the check has passed
          if (hit_q)
          begin
            sub_d = psub_q;
            rw_d = word_raw[CTRL_RW_BIT];
            int_d = word_raw[CTRL_INT_BIT];
          end
          fr_d = hit_q ? FR_DATA : FR_IDLE;
        end
        EV_HDR_ERR:
        begin
          // address is untrusted, so every slave reports and nobody acts
          hdr_err = 1'b1;
          fr_d = FR_IDLE;
        end
        EV_DATA:
          if (fr_q == FR_DATA)
          begin
            dv_d = 1'b1;
            db_d = word_raw;
          end
        default:
          if (fr_q == FR_DATA)
          begin
            done_d = 1'b1;
            bad_d = (kind_raw == EV_END_ERR);
            dat_err = (kind_raw == EV_END_ERR);
            fr_d = FR_IDLE;
          end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fr_q <= FR_IDLE;
      hit_q <= 1'b0;
      rw_q <= 1'b0;
      int_q <= 1'b0;
      sub_q <= 8'h00;
      psub_q <= 8'h00;
      db_q <= 8'h00;
      dv_q <= 1'b0;
      done_q <= 1'b0;
      bad_q <= 1'b0;
    end
    else
    begin
      fr_q <= fr_d;
      hit_q <= hit_d;
      rw_q <= rw_d;
      int_q <= int_d;
      sub_q <= sub_d;
      psub_q <= psub_d;
      db_q <= db_d;
      dv_q <= dv_d;
      done_q <= done_d;
      bad_q <= bad_d;
    end
  end

  // three copies voted each cycle, so one upset copy is outvoted and rewritten
  logic [ST_WIDTH-1:0] s0_q, s1_q, s2_q, vote, set, st_next, ist_q;
  logic pend_q, pend_d, tx_busy, tx_go;

  always_comb
  begin
    vote = maj3(s0_q, s1_q, s2_q);
    set = STATUS_RST;
    set[ST_HDR_BIT] = hdr_err;
    set[ST_DATA_BIT] = dat_err;
    set[ST_USER_BIT] = u_rise;
    // a set in the clearing cycle survives the read
    st_next = (vote & ~{ST_WIDTH{status_read}}) | set;
    tx_go = pend_q && !tx_busy;
    pend_d = (pend_q && !tx_go) || (|set);
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s0_q <= STATUS_RST;
      s1_q <= STATUS_RST;
      s2_q <= STATUS_RST;
      ist_q <= STATUS_RST;
      pend_q <= 1'b0;
    end
    else
    begin
      s0_q <= st_next;
      s1_q <= st_next;
      s2_q <= st_next;
      ist_q <= vote;
      pend_q <= pend_d;
    end
  end

  // no arbitration here: the line is assumed free when a frame is queued
  irq_tx u_irq_tx (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .start(tx_go),
    .addr(slave_addr),
    .busy(tx_busy),
    .sm_clk(sm_clk),
    .sm_data(sm_data),
    .sm_oe(sm_oe)
  );

  assign data_valid = dv_q;
  assign data_byte = db_q;
  assign data_sub = sub_q;
  assign data_rd = rw_q;
  assign data_int = int_q;
  assign frame_done = done_q;
  assign frame_data_bad = bad_q;
  assign irq_status = ist_q;
  assign irq_pending = pend_q;

  chk_hdr_err_drop: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ev_hit && kind_raw == EV_HDR_ERR) |=> (fr_q == FR_IDLE && !dv_q) ##1 !dv_q)
    else $error("frame with bad header was not dropped");

  chk_hdr_err_send: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ev_hit && kind_raw == EV_HDR_ERR) |-> ##[1:300] $rose(sm_oe))
    else $error("no interrupt frame after a header error");

  chk_data_kept: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ev_hit && kind_raw == EV_DATA && fr_q == FR_DATA) |=>
      (data_valid && data_byte == $past(word_raw)))
    else $error("received data word not delivered");

  chk_data_err_pend: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ev_hit && kind_raw == EV_END_ERR && fr_q == FR_DATA) |=> irq_pending ##1
      irq_status[ST_DATA_BIT])
    else $error("trailer mismatch not reported");

  chk_user_rec: assert property (@(posedge sys_clk) disable iff (!rst_b)
    u_rise |=> irq_pending ##1 irq_status[ST_USER_BIT])
    else $error("user interrupt not recorded");

  chk_status_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !status_read |=> ((vote & $past(vote)) == $past(vote)))
    else $error("recorded interrupt kind lost before a status read");

  chk_tmr_outvote: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s0_q != s1_q && s1_q == s2_q) |=> (s0_q == s1_q && s1_q == s2_q))
    else $error("upset status copy was not repaired");
endmodule // cfg_slave_err

// [sim/cfg_master_model.sv]
`timescale 1ns/1ns
module cfg_master_model
(
  output logic link_clk,
  output logic frame_start,
  output logic rx_bit
);
  initial
  begin
    link_clk = 1'b0;
    frame_start = 1'b0;
    rx_bit = 1'b1;
  end

  // link clock runs only inside a frame and stands low between frames
  task automatic send_frame(input logic [8:0] fw [0:7], input int n);
    for (int i = 0; i < n; i++)
    begin
      for (int b = 0; b < 9; b++)
      begin
        frame_start = (i == 0 && b == 0);
        rx_bit = fw[i][b];
        #32 link_clk = 1'b1;
        #32 link_clk = 1'b0;
      end
      // line no longer held: show the inverse, not the last bit
      rx_bit = ~rx_bit;
      #64;
    end
    frame_start = 1'b0;
  endtask
endmodule // cfg_master_model

// [sim/cfg_slave_err_tb_top.sv]
`timescale 1ns/1ns
module cfg_slave_err_tb_top;
  import cfg_err_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b1;
  logic link_clk, frame_start, rx_bit;
  logic [7:0] slave_addr = 8'h5A;
  logic user_irq_req = 1'b0;
  logic status_read = 1'b0;
  logic data_valid, data_rd, data_int, frame_done, frame_data_bad;
  logic irq_pending, sm_clk, sm_data, sm_oe;
  logic [7:0] data_byte, data_sub, dv_last;
  logic [ST_WIDTH-1:0] irq_status;
  logic [8:0] sm_word;
  logic [8:0] w [0:7];
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int n_dv = 0;
  int n_fd = 0;
  int n_sm = 0;
  int n_pend = 0;

  always #5 sys_clk = ~sys_clk;

  cfg_master_model u_cfg_master_model(.link_clk(link_clk), .frame_start(frame_start),
    .rx_bit(rx_bit));

  cfg_slave_err u_cfg_slave_err(.sys_clk(sys_clk), .rst_b(rst_b), .link_clk(link_clk),
    .frame_start(frame_start), .rx_bit(rx_bit), .slave_addr(slave_addr),
    .user_irq_req(user_irq_req), .status_read(status_read), .data_valid(data_valid),
    .data_byte(data_byte), .data_sub(data_sub), .data_rd(data_rd), .data_int(data_int),
    .frame_done(frame_done), .frame_data_bad(frame_data_bad), .irq_status(irq_status),
    .irq_pending(irq_pending), .sm_clk(sm_clk), .sm_data(sm_data), .sm_oe(sm_oe));

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // whole run needs about 3000 cycles; outputs looked at where settled
  always @(negedge sys_clk)
  begin
    cycles++;
    if (irq_pending === 1'b1)
      n_pend++;
    if (data_valid === 1'b1)
    begin
      n_dv++;
      dv_last = data_byte;
    end
    if (frame_done === 1'b1)
      n_fd++;
    if (cycles == 20000)
    begin
      mismatches++;
      test_done();
    end
  end

  // sample the interrupt frame where the master would: rising sm_clk
  always @(posedge sm_clk)
    if (sm_oe === 1'b1)
    begin
      if (n_sm < 9)
        sm_word[n_sm] = sm_data;
      n_sm++;
    end

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // hx corrupts the header check, tx the trailer
  task automatic mk(input logic [7:0] a, input logic [7:0] s, input logic [7:0] c,
    input int nd, input logic [3:0] hx, input logic [7:0] tx);
    logic [7:0] t;
    t = 8'h00;
    n_dv = 0;
    n_fd = 0;
    n_sm = 0;
    n_pend = 0;
    w[0] = {1'b0, a};
    w[1] = {1'b0, s};
    w[2] = {1'b0, c[7:4], a[3:0] ^ a[7:4] ^ s[3:0] ^ s[7:4] ^ c[7:4] ^ hx};
    for (int i = 0; i < nd; i++)
    begin
      w[3 + i] = {1'b0, 8'h3C + 8'(i) * 8'h11};
      t ^= w[3 + i][7:0];
    end
    w[3 + nd] = {1'b1, t ^ tx};
    u_cfg_master_model.send_frame(w, 4 + nd);
  endtask

  task automatic rd_status();
    @(negedge sys_clk);
    status_read = 1'b1;
    @(negedge sys_clk);
    status_read = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk(9'(irq_status), 9'h000);
  endtask

  task automatic t_good();
    mk(8'h5A, 8'h21, 8'hC0, 3, 4'h0, 8'h00);
    repeat (20) @(negedge sys_clk);
    chk(9'(n_dv), 9'h003);
    chk({1'b0, dv_last}, 9'h05E);
    chk({1'b0, data_sub}, 9'h021);
    chk({7'h00, data_rd, data_int}, 9'h003);
    chk(9'(n_fd), 9'h001);
    chk({8'h00, frame_data_bad}, 9'h000);
    chk(9'(irq_status), 9'h000);
    // other slave's frame with a bad trailer: no output, no report here
    mk(8'h33, 8'h44, 8'h00, 1, 4'h0, 8'h01);
    repeat (20) @(negedge sys_clk);
    chk(9'(n_dv + n_fd + n_pend), 9'h000);
    chk({1'b0, data_sub}, 9'h021);
    chk({7'h00, data_rd, data_int}, 9'h003);
    chk(9'(irq_status), 9'h000);
  endtask

  task automatic t_hdr();
    mk(8'h5A, 8'h22, 8'h80, 2, 4'h1, 8'h00);
    // interrupt already complete while the frame was still arriving
    chk(9'(n_sm), 9'h00A);
    chk(sm_word, {1'b1, slave_addr});
    repeat (20) @(negedge sys_clk);
    chk(9'(n_dv + n_fd), 9'h000);
    chk(9'(n_pend), 9'h001);
    chk({1'b0, data_sub}, 9'h021);
    chk(9'(irq_status), 9'h001);
    rd_status();
    // master repeats the transfer after the error report
    mk(8'h5A, 8'h22, 8'h80, 2, 4'h0, 8'h00);
    repeat (20) @(negedge sys_clk);
    chk(9'(n_dv + n_fd), 9'h003);
    chk({1'b0, data_sub}, 9'h022);
    chk({1'b0, frame_data_bad, 7'(n_pend)}, 9'h000);
  endtask

  task automatic t_data();
    mk(8'h5A, 8'h23, 8'h00, 2, 4'h0, 8'h01);
    repeat (150) @(negedge sys_clk);
    chk(9'(n_dv), 9'h002);
    chk({1'b0, dv_last}, 9'h04D);
    chk({7'h00, data_rd, data_int}, 9'h000);
    chk({1'b0, frame_data_bad, 7'(n_fd)}, 9'h081);
    chk(9'(irq_status), 9'h002);
    chk(9'(n_sm), 9'h00A);
    chk(9'(n_pend), 9'h001);
    chk(sm_word, {1'b1, slave_addr});
    rd_status();
  endtask

  task automatic t_user();
    @(negedge sys_clk);
    user_irq_req = 1'b1;
    repeat (10) @(negedge sys_clk);
    chk(9'(irq_status), 9'h004);
    mk(8'h5A, 8'h24, 8'h40, 0, 4'h8, 8'h00);
    repeat (150) @(negedge sys_clk);
    chk(9'(irq_status), 9'h005);
    chk(9'(n_sm), 9'h014);
    chk(sm_word, {1'b1, slave_addr});
    user_irq_req = 1'b0;
    rd_status();
  endtask

  initial
  begin
    // a real falling edge: the idle link side resets on nothing else
    #1 rst_b = 1'b0;
    repeat (12) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk({sm_oe, sm_clk, sm_data, 6'(irq_status)}, 9'h0C0);
    t_good();
    t_hdr();
    t_data();
    t_user();
    test_done();
  end
endmodule // cfg_slave_err_tb_top
